// ==== design/longline_resolver.sv ====
`timescale 1ns/1ns
`default_nettype none

module longline_resolver #(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // drivers on this line
    input  wire logic [N-1:0] drive_en,
    input  wire logic [N-1:0] drive_val,
    input  wire logic         pullup_on,
    // resolved line
    output logic              level,
    output logic              contend,
    output logic              kept
);
    import longline_pkg::*;

    // any low driver wins, released drivers count as high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= LINE_RST;
        end else if (|drive_en) begin
            level <= &(drive_val | ~drive_en);
        end else if (pullup_on) begin
            level <= 1'b1;
        end
    end

    // high and low drive at once burns current in silicon
    assign contend = (|(drive_en & drive_val)) & (|(drive_en & ~drive_val));
    assign kept    = ~(|drive_en) & ~pullup_on;

endmodule : longline_resolver

`default_nettype wire

// ==== design/tristate_longline_wide_decoder.sv ====
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tristate_longline_wide_decoder (
    // clock and reset
    input  wire logic                                      pclk,
    input  wire logic                                      presetn,
    // apb slave
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [longline_pkg::ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                               pwdata,
    output logic      [31:0]                               prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    // buffer inputs from logic and io blocks
    input  wire logic [longline_pkg::NBUF-1:0]             buf_in,
    input  wire logic [longline_pkg::NBUF-1:0]             or_input_b,
    input  wire logic [longline_pkg::NBUF-1:0]             buf_t,
    // resolved horizontal longlines
    output logic      [longline_pkg::LINES-1:0]            line_level,
    // edge decoder inputs
    input  wire logic [longline_pkg::EDGES*longline_pkg::PAD_WIDTH-1:0]
                                                           dec_pad_in,
    input  wire logic [longline_pkg::EDGES*longline_pkg::LOCAL_WIDTH-1:0]
                                                           dec_local_in,
    // edge decoder outputs
    output logic      [longline_pkg::NDEC_OUT-1:0]         dec_logic_out,
    output logic      [longline_pkg::NDEC_OUT-1:0]         dec_pad_out,
    output logic      [longline_pkg::NDEC_OUT-1:0]         dec_pad_oe
);
    import longline_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    buf_mode_e              buf_mode [NBUF];
    logic [NBUF-1:0]        drv_en;
    logic [NBUF-1:0]        drv_val;
    logic [NBUF-1:0]        line_en [LINES];
    logic [LINES-1:0]       pullup_sel;
    logic [LINES-1:0]       line_contend;
    logic [LINES-1:0]       line_kept;
    logic [LINES-1:0]       contend_flag;
    logic [LINES-1:0]       kept_now;
    logic [NDEC-1:0]        dec_split;
    logic [NDEC_OUT-1:0]    pad_en;
    logic [NDEC_OUT-1:0]    dec_comb;
    logic [DEC_WIDTH-1:0]   dec_mask [NDEC];
    logic [DEC_WIDTH-1:0]   dec_pol [NDEC];
    logic [EDGES*PAD_WIDTH-1:0] pad_meta;
    logic [EDGES*PAD_WIDTH-1:0] pad_sync;
    logic                   setup_ph;
    logic                   acc_wr;
    logic                   mode_hit;
    logic                   dec_hit;
    logic [3:0]             mode_idx;
    logic [3:0]             dec_idx;
    logic [1:0]             dec_sub;
    logic                   addr_ok;
    logic [31:0]            next_prdata;

    ////////////////////////////////////////////////////////////////////////
    // buffer modes

    // each buffer decides whether it drives and what level
    for (genvar b = 0; b < NBUF; b++) begin : g_buf
        always_comb begin
            unique case (buf_mode[b])
                MODE_STANDARD: begin
                    drv_en[b]  = ~buf_t[b];
                    drv_val[b] = buf_in[b];
                end
                MODE_WAND: begin
                    drv_en[b]  = ~buf_in[b];
                    drv_val[b] = 1'b0;
                end
                MODE_OR_AND: begin
                    drv_en[b]  = ~(buf_in[b] | or_input_b[b]);
                    drv_val[b] = 1'b0;
                end
                MODE_OFF: begin
                    drv_en[b]  = 1'b0;
                    drv_val[b] = 1'b1;
                end
            endcase
        end

        // block buffer pairs reach line r and r+1, edge ones line r
        localparam int LN = (b < BLK_BUFS) ? (b / (2 * COLS)) + (b % 2)
                                           : (b - BLK_BUFS) / 2;
        for (genvar l = 0; l < LINES; l++) begin : g_map
            assign line_en[l][b] = drv_en[b] & (LN == l);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // longline resolution

    // keeper, pull-up and wired and sit in one resolver per line
    for (genvar l = 0; l < LINES; l++) begin : g_line
        longline_resolver #(
            .N         (NBUF)
        ) u_line (
            .pclk      (pclk),
            .presetn   (presetn),
            .drive_en  (line_en[l]),
            .drive_val (drv_val),
            .pullup_on (pullup_sel[l]),
            .level     (line_level[l]),
            .contend   (line_contend[l]),
            .kept      (line_kept[l])
        );
    end

    // sticky contention per line; a fresh event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contend_flag <= '0;
        end else begin
            for (int l = 0; l < LINES; l++) begin
                if (line_contend[l]) begin
                    contend_flag[l] <= 1'b1;
                end else if (acc_wr && paddr == OFF_CONTEND
                             && pwdata[l]) begin
                    contend_flag[l] <= 1'b0;
                end
            end
        end
    end

    // keeper status sampled so reads see one stable word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kept_now <= '0;
        end else begin
            kept_now <= line_kept;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge decoders

    // pads are asynchronous to pclk, two stages before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_meta <= '0;
            pad_sync <= '0;
        end else begin
            pad_meta <= dec_pad_in;
            pad_sync <= pad_meta;
        end
    end

    // four decoders per edge share that edge's inputs
    for (genvar d = 0; d < NDEC; d++) begin : g_dec
        localparam int E = d / DEC_PER_EDGE;
        wide_decoder u_dec (
            .data   ({dec_local_in[E*LOCAL_WIDTH +: LOCAL_WIDTH],
                      pad_sync[E*PAD_WIDTH +: PAD_WIDTH]}),
            .mask   (dec_mask[d]),
            .pol    (dec_pol[d]),
            .split  (dec_split[d]),
            .out_lo (dec_comb[2*d]),
            .out_hi (dec_comb[2*d+1])
        );
    end

    // decoder results to logic blocks and pads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_logic_out <= '0;
            dec_pad_out   <= '0;
            dec_pad_oe    <= '0;
        end else begin
            dec_logic_out <= dec_comb;
            dec_pad_out   <= dec_comb;
            dec_pad_oe    <= pad_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup_ph = psel & ~penable;
    assign acc_wr   = psel & penable & pready & pwrite & addr_ok;
    assign mode_hit = paddr[11:6] == OFF_MODE[11:6]
                      && paddr[5:2] < 4'(MODE_WORDS);
    assign dec_hit  = paddr[11:8] == OFF_DEC[11:8];
    assign mode_idx = paddr[5:2];
    assign dec_idx  = paddr[7:4];
    assign dec_sub  = paddr[3:2];

    // read mux; unmapped or unaligned addresses answer an error
    always_comb begin
        next_prdata = '0;
        addr_ok     = paddr[1:0] == 2'b00;
        if (mode_hit) begin
            for (int b = 0; b < NBUF; b++) begin
                if (b / MODE_PER_WORD == int'(mode_idx)) begin
                    next_prdata[(b % MODE_PER_WORD)*2 +: 2] = buf_mode[b];
                end
            end
        end else if (dec_hit) begin
            unique case (dec_sub)
                2'd0: next_prdata = dec_mask[dec_idx][31:0];
                2'd1: next_prdata[DEC_HI_W-1:0] =
                          dec_mask[dec_idx][DEC_WIDTH-1:32];
                2'd2: next_prdata = dec_pol[dec_idx][31:0];
                2'd3: next_prdata[DEC_HI_W-1:0] =
                          dec_pol[dec_idx][DEC_WIDTH-1:32];
            endcase
        end else begin
            unique case (paddr)
                OFF_PULLUP:  next_prdata[LINES-1:0] = pullup_sel;
                OFF_LINE:    next_prdata[LINES-1:0] = line_level;
                OFF_SPLIT:   next_prdata[NDEC-1:0]  = dec_split;
                OFF_DEC_OUT: next_prdata            = dec_logic_out;
                OFF_PAD_EN:  next_prdata            = pad_en;
                OFF_CONTEND: next_prdata[LINES-1:0] = contend_flag;
                OFF_KEEP:    next_prdata[LINES-1:0] = kept_now;
                default:     addr_ok                = 1'b0;
            endcase
        end
    end

    // one wait-free access phase: answer is prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite) begin
                prdata <= addr_ok ? next_prdata : '0; // refused reads give 0
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    // line pull-ups, decoder splits and pad enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_sel <= PULLUP_RST[LINES-1:0];
            dec_split  <= SPLIT_RST[NDEC-1:0];
            pad_en     <= PAD_EN_RST;
        end else if (acc_wr) begin
            unique case (paddr)
                OFF_PULLUP: pullup_sel <= pwdata[LINES-1:0];
                OFF_SPLIT:  dec_split  <= pwdata[NDEC-1:0];
                OFF_PAD_EN: pad_en     <= pwdata;
                default:    ;
            endcase
        end
    end

    // buffer modes, sixteen per word; all start released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < NBUF; b++) begin
                buf_mode[b] <= MODE_OFF;
            end
        end else if (acc_wr && mode_hit) begin
            for (int b = 0; b < NBUF; b++) begin
                if (b / MODE_PER_WORD == int'(mode_idx)) begin
                    buf_mode[b] <= buf_mode_e'(
                        pwdata[(b % MODE_PER_WORD)*2 +: 2]);
                end
            end
        end
    end

    // per-decoder input select and complement, low and high words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int d = 0; d < NDEC; d++) begin
                dec_mask[d] <= '0;
                dec_pol[d]  <= '0;
            end
        end else if (acc_wr && dec_hit) begin
            unique case (dec_sub)
                2'd0: dec_mask[dec_idx][31:0] <= pwdata;
                2'd1: dec_mask[dec_idx][DEC_WIDTH-1:32] <=
                          pwdata[DEC_HI_W-1:0];
                2'd2: dec_pol[dec_idx][31:0] <= pwdata;
                2'd3: dec_pol[dec_idx][DEC_WIDTH-1:32] <=
                          pwdata[DEC_HI_W-1:0];
            endcase
        end
    end

endmodule : tristate_longline_wide_decoder

`default_nettype wire

// ==== design/wide_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none

module wide_decoder (
    // inputs and per-input configuration
    input  wire logic [longline_pkg::DEC_WIDTH-1:0] data,
    input  wire logic [longline_pkg::DEC_WIDTH-1:0] mask,
    input  wire logic [longline_pkg::DEC_WIDTH-1:0] pol,
    input  wire logic                               split,
    // product terms
    output logic                                    out_lo,
    output logic                                    out_hi
);
    import longline_pkg::*;

    logic [DEC_WIDTH-1:0] term;
    logic                 full;

    // unselected inputs float high, like a released open drain
    assign term   = ~mask | (data ^ pol);
    assign full   = &term;
    assign out_lo = split ? &term[DEC_HALF-1:0] : full;
    assign out_hi = split ? &term[DEC_WIDTH-1:DEC_HALF] : full;

endmodule : wide_decoder

`default_nettype wire

// ==== inc/longline_pkg.sv ====
package longline_pkg;

    // array geometry
    localparam int ROWS         = 4;
    localparam int COLS         = 4;
    localparam int LINES        = ROWS + 1;
    localparam int BLK_BUFS     = 2 * ROWS * COLS;
    localparam int NBUF         = BLK_BUFS + 2 * ROWS;

    // edge decoders
    localparam int EDGES        = 4;
    localparam int DEC_PER_EDGE = 4;
    localparam int NDEC         = EDGES * DEC_PER_EDGE;
    localparam int NDEC_OUT     = 2 * NDEC;
    localparam int DEC_WIDTH    = 42;
    localparam int DEC_HALF     = DEC_WIDTH / 2;
    localparam int LOCAL_PER    = 3;
    localparam int LOCAL_WIDTH  = LOCAL_PER * COLS;
    localparam int PAD_WIDTH    = DEC_WIDTH - LOCAL_WIDTH;
    localparam int DEC_HI_W     = DEC_WIDTH - 32;

    // buffer configuration
    localparam int MODE_PER_WORD = 16;
    localparam int MODE_WORDS    = 3;

    typedef enum logic [1:0] {
        MODE_OFF      = 2'b00,
        MODE_STANDARD = 2'b01,
        MODE_WAND     = 2'b10,
        MODE_OR_AND   = 2'b11
    } buf_mode_e;

    // register offsets, byte addresses
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] OFF_PULLUP   = 12'h000;
    localparam logic [11:0] OFF_LINE     = 12'h004;
    localparam logic [11:0] OFF_SPLIT    = 12'h008;
    localparam logic [11:0] OFF_DEC_OUT  = 12'h00c;
    localparam logic [11:0] OFF_PAD_EN   = 12'h010;
    localparam logic [11:0] OFF_CONTEND  = 12'h014;
    localparam logic [11:0] OFF_KEEP     = 12'h018;
    localparam logic [11:0] OFF_MODE     = 12'h040;
    localparam logic [11:0] OFF_DEC      = 12'h100;

    // values after reset
    localparam logic [31:0] PULLUP_RST = 32'h0000_0000;
    localparam logic [31:0] SPLIT_RST  = 32'h0000_0000;
    localparam logic [31:0] PAD_EN_RST = 32'h0000_0000;
    localparam logic        LINE_RST   = 1'b1;

endpackage : longline_pkg

// ==== verif/block_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module block_model #(
    parameter int N = longline_pkg::NBUF
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // what the bench wants the blocks to do
    input  wire logic [N-1:0] want_in,
    input  wire logic [N-1:0] want_b,
    input  wire logic [N-1:0] want_t,
    input  wire logic         mux_on,
    input  wire logic [5:0]   mux_sel,
    // buffer pins as the logic and io blocks drive them
    output logic      [N-1:0] buf_in,
    output logic      [N-1:0] or_input_b,
    output logic      [N-1:0] buf_t
);
    import longline_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // block outputs are flops, so they move only after a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_in     <= '0;
            or_input_b <= '0;
            buf_t      <= '1;
        end else begin
            buf_in     <= want_in;
            or_input_b <= want_b;
            // one-hot select avoids two sources fighting on a line
            buf_t      <= mux_on ? ~(N'(1) << mux_sel) : want_t;
        end
    end
endmodule : block_model

`default_nettype wire

// ==== verif/longline_chk.sv ====
`timescale 1ns/1ns
`default_nettype none

module longline_chk (
    // clock and reset
    input wire logic                              pclk,
    input wire logic                              presetn,
    // apb slave side
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [31:0]                       prdata,
    input wire logic                              pready,
    input wire logic                              pslverr,
    // buffers and lines
    input wire logic [longline_pkg::NBUF-1:0]     buf_in,
    input wire logic [longline_pkg::NBUF-1:0]     or_input_b,
    input wire logic [longline_pkg::NBUF-1:0]     buf_t,
    input wire logic [longline_pkg::LINES-1:0]    line_level,
    // decoder outputs
    input wire logic [longline_pkg::NDEC_OUT-1:0] dec_logic_out,
    input wire logic [longline_pkg::NDEC_OUT-1:0] dec_pad_out,
    input wire logic [longline_pkg::NDEC_OUT-1:0] dec_pad_oe
);
    import longline_pkg::*;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: the slave is wait-free by design
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
        else $error("refused read returned data");

    ////////////////////////////////////////////////////////////////////////
    // decoder outputs: pad copy equals logic copy, enables move on writes
    dec_copies_a: assert property (dec_logic_out == dec_pad_out)
        else $error("decoder copies differ");
    oe_by_write_a: assert property (!$stable(dec_pad_oe) |->
        $past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))
        else $error("pad enable moved without a write");

    // quiet drivers and no config write leave every line where it was
    line_stable_a: assert property (!psel && $past(!psel) &&
        $past(presetn) && $stable(buf_in) && $stable(buf_t) &&
        $stable(or_input_b) |=> $stable(line_level))
        else $error("line moved with quiet drivers");

    ////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    cover property (psel && penable && pready && pwrite);
    cover property (pready && pslverr);
    cover property ($fell(line_level[0]));
endmodule : longline_chk

bind tristate_longline_wide_decoder longline_chk i_longline_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .buf_in, .or_input_b, .buf_t, .line_level,
    .dec_logic_out, .dec_pad_out, .dec_pad_oe
);

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import longline_pkg::*;

    // clock, reset, apb
    logic                         pclk = 1'b0;
    logic                         presetn = 1'b0;
    logic                         psel = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite = 1'b0;
    logic [ADDR_W-1:0]            paddr = '0;
    logic [31:0]                  pwdata = '0;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    // partner requests and buffer pins
    logic [NBUF-1:0]              want_in = '0;
    logic [NBUF-1:0]              want_b = '0;
    logic [NBUF-1:0]              want_t = '1;
    logic                         mux_on = 1'b0;
    logic [5:0]                   mux_sel = '0;
    logic [NBUF-1:0]              buf_in;
    logic [NBUF-1:0]              or_input_b;
    logic [NBUF-1:0]              buf_t;
    logic [LINES-1:0]             line_level;
    // decoders
    logic [EDGES*PAD_WIDTH-1:0]   dec_pad_in = '0;
    logic [EDGES*LOCAL_WIDTH-1:0] dec_local_in = '0;
    logic [NDEC_OUT-1:0]          dec_logic_out;
    logic [NDEC_OUT-1:0]          dec_pad_out;
    logic [NDEC_OUT-1:0]          dec_pad_oe;
    // bookkeeping
    logic [31:0]                  q;
    logic                         e;
    int                           miscompares = 0;
    int                           n_checks = 0;

    // free-running 100 MHz clock
    always #5 pclk = ~pclk;

    block_model i_block_model (.pclk, .presetn, .want_in, .want_b,
        .want_t, .mux_on, .mux_sel, .buf_in, .or_input_b, .buf_t);

    tristate_longline_wide_decoder i_tristate_longline_wide_decoder (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .buf_in, .or_input_b, .buf_t,
        .line_level, .dec_pad_in, .dec_local_in, .dec_logic_out,
        .dec_pad_out, .dec_pad_oe);

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // one transfer, then an idle edge so psel is never set twice at once
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            wrap_up();
        end else begin
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(nm, q, exp);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rd("pullup", OFF_PULLUP, PULLUP_RST);
        rd("split", OFF_SPLIT, SPLIT_RST);
        rd("pad en", OFF_PAD_EN, PAD_EN_RST);
        rd("line", OFF_LINE, 32'({LINES{LINE_RST}}));
    endtask : t_reset

    task automatic t_standard;
        apb(1'b1, OFF_MODE, 32'(MODE_STANDARD));
        want_in[0] <= 1'b1;
        want_t[0]  <= 1'b0;
        cyc(3);
        chk("pass high", 32'(line_level[0]), 32'h1);
        want_in[0] <= 1'b0;
        cyc(3);
        chk("pass low", 32'(line_level[0]), 32'h0);
        want_in[0] <= 1'b1;
        want_t[0]  <= 1'b1;
        cyc(3);
        chk("keeper", 32'(line_level[0]), 32'h0);
        apb(1'b1, OFF_PULLUP, 32'h0000_0001);
        cyc(3);
        chk("pull-up", 32'(line_level[0]), 32'h1);
        want_in[0] <= 1'b0;
        want_t[0]  <= 1'b0;
        cyc(3);
        chk("driver wins", 32'(line_level[0]), 32'h0);
        want_t[0] <= 1'b1;
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_PULLUP, 32'h0);
    endtask : t_standard

    // buffers 1 and 3 reach line 1 from below; t is left high on purpose
    task automatic t_wand;
        apb(1'b1, OFF_PULLUP, 32'h0000_0002);
        apb(1'b1, OFF_MODE, (32'(MODE_WAND) << 2) | (32'(MODE_WAND) << 6));
        for (int k = 0; k < 4; k++) begin
            want_in[1] <= k[0];
            want_in[3] <= k[1];
            cyc(3);
            chk("wired and", 32'(line_level[1]), 32'(k == 3));
        end
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_PULLUP, 32'h0);
    endtask : t_wand

    // edge buffer 32 sits beside the left io block of row 0
    task automatic t_orand;
        apb(1'b1, OFF_PULLUP, 32'h0000_0001);
        apb(1'b1, OFF_MODE + 12'h008, 32'(MODE_OR_AND));
        for (int k = 0; k < 4; k++) begin
            want_in[32] <= k[0];
            want_b[32]  <= k[1];
            cyc(3);
            chk("or-and", 32'(line_level[0]), 32'(k != 0));
        end
        apb(1'b1, OFF_MODE + 12'h008, 32'h0);
        apb(1'b1, OFF_PULLUP, 32'h0);
    endtask : t_orand

    task automatic t_mux;
        apb(1'b1, OFF_MODE,
            32'(MODE_STANDARD) | (32'(MODE_STANDARD) << 4));
        want_in[0] <= 1'b1;
        want_in[2] <= 1'b0;
        mux_on     <= 1'b1;
        for (int s = 0; s <= 2; s += 2) begin
            mux_sel <= 6'(s);
            cyc(3);
            chk("mux", 32'(line_level[0]), 32'(s == 0));
        end
        rd("contend", OFF_CONTEND, 32'h0);
        // both sources on at once: low wins, contention sticks until cleared
        mux_on      <= 1'b0;
        want_t[2:0] <= 3'b010;
        cyc(3);
        chk("fight", 32'(line_level[0]), 32'h0);
        rd("keep", OFF_KEEP, 32'h0000_001e);
        rd("contend set", OFF_CONTEND, 32'h1);
        want_t[2:0] <= 3'b111;
        apb(1'b1, OFF_CONTEND, 32'h1);
        rd("contend clr", OFF_CONTEND, 32'h0);
        apb(1'b1, OFF_MODE, 32'h0);
    endtask : t_mux

    // pad path has three cycles of latency, so five is ample
    task automatic t_dec;
        for (int ed = 0; ed < EDGES; ed++) begin
            apb(1'b1, OFF_DEC + 12'(ed * 64), 32'h0000_0001);
            cyc(5);
            chk("edge low", 32'(dec_logic_out[ed*8 +: 2]), 32'h0);
            dec_pad_in[ed*PAD_WIDTH] <= 1'b1;
            cyc(5);
            chk("edge high", 32'(dec_logic_out[ed*8 +: 2]), 32'h3);
        end
        apb(1'b1, OFF_DEC, 32'h4000_0001);
        apb(1'b1, OFF_DEC + 12'h008, 32'h4000_0000);
        cyc(5);
        chk("complement", 32'(dec_logic_out[1:0]), 32'h3);
        dec_local_in[0] <= 1'b1;
        cyc(5);
        chk("local", 32'(dec_logic_out[1:0]), 32'h0);
        apb(1'b1, OFF_SPLIT, 32'h0000_0001);
        cyc(5);
        chk("split", 32'(dec_logic_out[1:0]), 32'h1);
        apb(1'b1, OFF_PAD_EN, 32'h0000_0003);
        cyc(2);
        chk("pad oe", dec_pad_oe, 32'h0000_0003);
        chk("pad out", 32'(dec_pad_out[1:0]), 32'h1);
    endtask : t_dec

    task automatic t_err;
        apb(1'b0, 12'h020, '0);
        chk("unmapped flag", 32'(e), 32'h1);
        chk("unmapped data", q, 32'h0);
        // decoder 0 mask is still set, so a leak would show here
        apb(1'b0, OFF_DEC + 12'h001, '0);
        chk("unaligned read flag", 32'(e), 32'h1);
        chk("unaligned read data", q, 32'h0);
        apb(1'b1, 12'h002, 32'hffff_ffff);
        chk("unaligned flag", 32'(e), 32'h1);
    endtask : t_err

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cyc(2);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_standard();
        t_wand();
        t_orand();
        t_mux();
        t_dec();
        t_err();
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
